//--- include/ipsb_pkg.sv
`default_nettype none

package ipsb_pkg;

  // ----------------------------------------------------------------
  // Register map and bus answers.
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_PEND_SET_WORD0 = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_PEND_SET_WORD1 = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PEND_CLR_WORD0 = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PEND_CLR_WORD1 = 12'h00C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Implemented pending positions of each word.
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_WORD0 = 32'h7FFFC0FF;
  localparam logic [31:0] MASK_WORD1 = 32'h0CFFFFEF;
  localparam logic [63:0] MASK_ALL = {MASK_WORD1, MASK_WORD0};

  // ----------------------------------------------------------------
  // State of the bank.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0] pend;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipsb_state_s;

  localparam ipsb_state_s STATE_RESET = '0;

endpackage : ipsb_pkg

`default_nettype wire

//--- hw/ipsb_bank.sv
// Notes on behaviour
// - Writing one to a set bit makes that interrupt pending.
// - A one does nothing when the interrupt is already pending or disabled.
// - Writing zero to a set bit leaves its pending state alone.
// - Reading a set bit returns the live pending state of that interrupt.
// - Writing one to the matching clear bit clears the pending bit.
// - Word zero holds interrupts 30 to 14 and 7 to 0, one bit each.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none

module ipsb_bank
  import ipsb_pkg::*;
(
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Write address channel.
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel.
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel.
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel.
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Interrupt side.
  input wire logic [63:0] irq_en,
  input wire logic [63:0] irq_req,
  output logic [63:0] pend_bits
);

  // ----------------------------------------------------------------
  // State and combinational helpers.
  // ----------------------------------------------------------------
  ipsb_state_s s;
  ipsb_state_s next_s;
  logic wr_go;
  logic ar_go;
  logic aw_go;
  logic w_go;
  logic [31:0] lane_mask;
  logic [31:0] wr_bits;
  logic [63:0] set_wr;
  logic [63:0] clr_wr;
  logic [63:0] set_req;
  logic [63:0] clr_req;
  logic [63:0] next_pend;
  logic wr_mapped;
  logic rd_mapped;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Bus handshakes.
  // ----------------------------------------------------------------
  assign awready = ce && !s.aw_held;
  assign wready = ce && !s.w_held;
  assign arready = ce && !s.rvalid;
  assign bvalid = ce && s.bvalid;
  assign rvalid = ce && s.rvalid;
  assign bresp = s.bresp;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign pend_bits = s.pend;

  assign aw_go = awvalid && awready;
  assign w_go = wvalid && wready;
  assign ar_go = arvalid && arready;
  assign wr_go = ce && s.aw_held && s.w_held && !s.bvalid;

  assign wr_mapped = (s.aw_addr == OFF_PEND_SET_WORD0) || (s.aw_addr == OFF_PEND_SET_WORD1)
    || (s.aw_addr == OFF_PEND_CLR_WORD0) || (s.aw_addr == OFF_PEND_CLR_WORD1);
  assign rd_mapped = (araddr == OFF_PEND_SET_WORD0) || (araddr == OFF_PEND_SET_WORD1)
    || (araddr == OFF_PEND_CLR_WORD0) || (araddr == OFF_PEND_CLR_WORD1);

  // ----------------------------------------------------------------
  // Write decode with byte lanes.
  // ----------------------------------------------------------------
  assign wr_bits = s.w_data & lane_mask;

  always_comb
  begin
    set_wr = '0;
    clr_wr = '0;
    if (wr_go)
    begin
      case (s.aw_addr)
        OFF_PEND_SET_WORD0: set_wr[31:0] = wr_bits & MASK_WORD0;
        OFF_PEND_SET_WORD1: set_wr[63:32] = wr_bits & MASK_WORD1;
        OFF_PEND_CLR_WORD0: clr_wr[31:0] = wr_bits & MASK_WORD0;
        OFF_PEND_CLR_WORD1: clr_wr[63:32] = wr_bits & MASK_WORD1;
        default: set_wr = '0;
      endcase
    end
  end

  assign set_req = (set_wr | (irq_req & MASK_ALL)) & irq_en & ~s.pend;
  assign clr_req = clr_wr;

  // ----------------------------------------------------------------
  // Per-bit pending logic and lane expansion.
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++)
    begin : g_bit
      // A set in the same cycle as a clear wins only for a bit not yet pending; a pending bit is cleared.
      assign next_pend[gi] = set_req[gi] | (s.pend[gi] & ~clr_req[gi]);
      if (gi < 32)
      begin : g_lane
        assign lane_mask[gi] = s.w_strb[gi / 8];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux.
  // ----------------------------------------------------------------
  always_comb
  begin
    case (araddr)
      OFF_PEND_SET_WORD0: rd_word = s.pend[31:0] & MASK_WORD0;
      OFF_PEND_CLR_WORD0: rd_word = s.pend[31:0] & MASK_WORD0;
      OFF_PEND_SET_WORD1: rd_word = s.pend[63:32] & MASK_WORD1;
      OFF_PEND_CLR_WORD1: rd_word = s.pend[63:32] & MASK_WORD1;
      default: rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.pend = next_pend & MASK_ALL;
    if (aw_go)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (w_go)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (ar_go)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= STATE_RESET;
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_set0_seq;
    wr_go && (s.aw_addr == OFF_PEND_SET_WORD0);
  endsequence

  sequence rd_set0_seq;
    ar_go && (araddr == OFF_PEND_SET_WORD0);
  endsequence

  a_set_makes_pend: assert property (
    wr_set0_seq |=> ((s.pend[31:0] & $past(wr_bits & MASK_WORD0 & irq_en[31:0]))
      == $past(wr_bits & MASK_WORD0 & irq_en[31:0]))
  ) else $error("Set write did not make the interrupt pending.");

  a_disabled_no_set: assert property (
    ce |=> ((s.pend & ~$past(s.pend) & ~$past(irq_en)) == 64'h0000000000000000)
  ) else $error("Disabled interrupt became pending.");

  a_quiet_bits_hold: assert property (
    ce |=> (((s.pend ^ $past(s.pend)) & ~$past(set_req | clr_req)) == 64'h0000000000000000)
  ) else $error("Pending bit changed without a set or clear.");

  a_read_live_state: assert property (
    rd_set0_seq |=> (s.rvalid && (s.rdata == ($past(s.pend[31:0]) & MASK_WORD0)))
  ) else $error("Read did not return the pending state.");

  a_clear_drops_bits: assert property (
    ce |=> ((s.pend & $past(clr_req & ~set_req)) == 64'h0000000000000000)
  ) else $error("Clear write left a pending bit set.");

  a_unused_pos_zero: assert property (
    (s.pend & ~MASK_ALL) == 64'h0000000000000000
  ) else $error("Unused pending position is set.");

  a_write_answered: assert property (
    wr_go |=> s.bvalid ##0 (s.bresp == $past(wr_mapped ? RESP_OKAY : RESP_SLVERR))
  ) else $error("Write response missing or wrong.");

  a_read_data_held: assert property (
    (rvalid && !rready && ce) |=> (s.rvalid && $stable(s.rdata))
  ) else $error("Read data changed before it was taken.");

endmodule : ipsb_bank

`default_nettype wire

//--- bench/ipsb_irq_src.sv
`default_nettype none

// ------------------------------------------------------------
// Request source and enable model.
// ------------------------------------------------------------
module ipsb_irq_src
  import ipsb_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Commands from the bench.
  input wire logic [63:0] en_cmd,
  input wire logic [63:0] req_cmd,
  // Interrupt side.
  output logic [63:0] irq_en,
  output logic [63:0] irq_req
);
  timeunit 1ns;
  timeprecision 1ns;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_en <= 64'h0;
      irq_req <= 64'h0;
    end
    else
    begin
      irq_en <= en_cmd;
      irq_req <= req_cmd;
    end
  end
endmodule : ipsb_irq_src

`default_nettype wire

//--- bench/tb_top.sv
`default_nettype none

module tb_top
  import ipsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [63:0] irq_en, irq_req, pend_bits, en_cmd, req_cmd;
  int mismatches, total_checks;

  ipsb_bank u_ipsb_bank (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .irq_en, .irq_req, .pend_bits);
  ipsb_irq_src u_ipsb_irq_src (.aclk, .aresetn, .en_cmd, .req_cmd, .irq_en, .irq_req);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Bus and check tasks.
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd_val = rdata;
    resp = rresp;
  endtask : rd

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (3000) @(posedge aclk);
    mismatches++;
    test_done();
  end

  // ------------------------------------------------------------
  // Test sequence.
  // ------------------------------------------------------------
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    en_cmd = 64'h0;
    req_cmd = 64'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_PEND_SET_WORD0);
    chk("reset word0", rd_val, 64'h0);
    chk("read resp", resp, RESP_OKAY);
    $display("test reset done");
    en_cmd <= MASK_ALL & ~64'h1;
    wr(OFF_PEND_SET_WORD0, 32'h40000081);
    chk("set disabled", pend_bits, 64'h40000080);
    chk("write resp", resp, RESP_OKAY);
    wr(OFF_PEND_SET_WORD0, MASK_WORD0);
    chk("set all word0", pend_bits, {32'h0, MASK_WORD0 & ~32'h1});
    wr(OFF_PEND_SET_WORD0, 32'h0);
    rd(OFF_PEND_SET_WORD0);
    chk("write zero", rd_val, MASK_WORD0 & ~32'h1);
    wr(OFF_PEND_CLR_WORD0, 32'h00004080);
    rd(OFF_PEND_SET_WORD0);
    chk("clear word0", rd_val, MASK_WORD0 & ~32'h4081);
    wstrb <= 4'h2;
    wr(OFF_PEND_SET_WORD0, 32'h00004080);
    wstrb <= 4'hF;
    chk("strobe lanes", pend_bits[31:0], MASK_WORD0 & ~32'h81);
    $display("test word0 done");
    wr(OFF_PEND_SET_WORD1, MASK_WORD1);
    rd(OFF_PEND_SET_WORD1);
    chk("set word1", rd_val, MASK_WORD1);
    wr(OFF_PEND_CLR_WORD1, MASK_WORD1);
    chk("clear word1", pend_bits[63:32], 64'h0);
    @(posedge aclk);
    req_cmd <= {32'h2, 32'h1};
    @(posedge aclk);
    req_cmd <= 64'h0;
    rd(OFF_PEND_SET_WORD1);
    chk("live word1", rd_val, 64'h2);
    chk("req disabled", pend_bits[0], 64'h0);
    $display("test word1 done");
    rd(12'h010);
    chk("unmapped read", {rd_val, 30'h0, resp}, {32'h0, 30'h0, RESP_SLVERR});
    wr(12'h010, 32'h1);
    chk("unmapped write", resp, RESP_SLVERR);
    $display("test unmapped done");
    @(posedge aclk);
    ce <= 1'b0;
    req_cmd <= 64'h80;
    repeat (3) @(posedge aclk);
    req_cmd <= 64'h0;
    repeat (2) @(posedge aclk);
    chk("frozen ready", {awready, wready, arready}, 64'h0);
    chk("frozen pend", pend_bits, {32'h2, MASK_WORD0 & ~32'h81});
    ce <= 1'b1;
    $display("test freeze done");
    test_done();
  end
endmodule : tb_top

`default_nettype wire
